/* pkg/lpt_port_pkg.sv */
package lpt_port_pkg;

  // Register offsets from the decoded base
  localparam logic [1:0]  off_data   = 2'h0;
  localparam logic [1:0]  off_status = 2'h1;
  localparam logic [1:0]  off_ctrl   = 2'h2;

  // Base address slots selected by jumpers
  localparam logic [9:0]  base_slot_first  = 10'h378;
  localparam logic [9:0]  base_slot_second = 10'h278;
  localparam logic [9:0]  base_slot_third  = 10'h3bc;

  // Status bit positions
  localparam int          st_busy_pos   = 7;
  localparam int          st_ack_pos    = 6;
  localparam int          st_paper_pos  = 5;
  localparam int          st_online_pos = 4;
  localparam int          st_error_pos  = 3;
  localparam logic [2:0]  st_low_ones   = 3'h7;

  // Control bit positions
  localparam int          ct_dir_pos    = 5;
  localparam int          ct_irqen_pos  = 4;
  localparam int          ct_select_pos = 3;
  localparam int          ct_init_pos   = 2;
  localparam int          ct_feed_pos   = 1;
  localparam int          ct_strobe_pos = 0;
  localparam logic [1:0]  ct_high_ones  = 2'h3;

  // Values after reset: lines idle, init released, port usable at once
  localparam logic [7:0]  data_reset    = 8'h00;
  localparam logic [5:0]  ctrl_reset    = 6'h04;

  // Port slot jumper choices
  typedef enum logic [1:0] {
    slot_first  = 2'b00,
    slot_second = 2'b01,
    slot_third  = 2'b10
  } slot_type;

  // Printer status lines as seen at the connector
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic paper_empty_flag;
    logic printer_online_flag;
    logic error_n;
  } status_lines_type;

  // Control lines as driven to the connector
  typedef struct packed {
    logic select;
    logic init_n;
    logic auto_feed;
    logic strobe;
  } ctrl_lines_type;

endpackage : lpt_port_pkg

/* src/lpt_sync2.sv */
`timescale 1ns/1ns
// Two flip-flop synchroniser for a bus of pin levels
module lpt_sync2 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : lpt_sync2

/* src/isa_printer_port.sv */
`timescale 1ns/1ns
// Contract
// - Data register at offset 0, bits map lines
// - Status at offset 1, low three bits one
// - Busy bit reads 0 when printer blocked
// - Ack bit reads 0 when printer ready
// - Paper, online, error bits reflect printer
// - Control at offset 2, top bits one
// - Direction bit honoured only in bidirectional mode
// - Direction one releases and reads data lines
// - Direction zero drives data register out
// - Interrupt enable raises request on ack low
// - Select one asserts, init zero asserts
// - Control outputs read back as written
// - Jumper makes data register bidirectional
// - Base from three jumper slots, IRQ line 7 or 5 by separate jumper
// - Exactly three consecutive addresses decoded
// - Delivery setting decodes second slot
// - Works after reset without software setup
module isa_printer_port (
  input  wire logic                           clk,
  input  wire logic                           nrst,
  // Host I/O bus
  input  wire logic [9:0]                     io_addr,
  input  wire logic                           io_rd,
  input  wire logic                           io_wr,
  input  wire logic [7:0]                     io_wdata,
  output logic      [7:0]                     io_rdata,
  output logic                                io_sel,
  // Jumpers
  input  wire lpt_port_pkg::slot_type         port_slot_jumper,
  input  wire logic                           port_mode_jumper,
  input  wire logic                           irq_choice_jumper,
  // Printer data lines
  input  wire logic [7:0]                     pd_in,
  output logic      [7:0]                     pd_out,
  output logic      [7:0]                     pd_oe,
  // Printer status and control lines
  input  wire lpt_port_pkg::status_lines_type status_pins,
  output lpt_port_pkg::ctrl_lines_type        ctrl_pins,
  // Interrupt request lines
  output logic                                irq_line7,
  output logic                                irq_line5
);
  import lpt_port_pkg::*;

  logic [7:0]       print_data_byte;
  logic [5:0]       printer_control_lines;
  logic [7:0]       pd_sync;
  status_lines_type st_sync;
  logic [9:0]       base_addr;
  logic [9:0]       rel_addr;
  logic             hit;
  logic [1:0]       reg_idx;
  logic             data_dir_in;
  logic [7:0]       printer_status_lines;
  logic [7:0]       ctrl_readback;
  logic [7:0]       next_rdata;
  logic             irq_req;

  // Pin levels pass two flops before use
  lpt_sync2 #(.W(8)) u_sync_data (
    .clk  (clk),
    .nrst (nrst),
    .din  (pd_in),
    .dout (pd_sync)
  );

  lpt_sync2 #(.W(5)) u_sync_status (
    .clk  (clk),
    .nrst (nrst),
    .din  (status_pins),
    .dout (st_sync)
  );

  // Base from the slot jumper; unknown codes fall back to delivery slot
  always_comb begin
    unique case (port_slot_jumper)
      slot_first:  base_addr = base_slot_first;
      slot_second: base_addr = base_slot_second;
      slot_third:  base_addr = base_slot_third;
      default:     base_addr = base_slot_second;
    endcase
  end

  // Three-address window decode
  assign rel_addr = io_addr - base_addr;
  assign hit      = (rel_addr < 10'h003);
  assign reg_idx  = rel_addr[1:0];

  // Direction only honoured in bidirectional mode
  assign data_dir_in = port_mode_jumper & printer_control_lines[ct_dir_pos];

  // Status byte built from synchronised lines
  always_comb begin
    printer_status_lines                = 8'h00;
    printer_status_lines[st_busy_pos]   = st_sync.busy;
    printer_status_lines[st_ack_pos]    = st_sync.ack_n;
    printer_status_lines[st_paper_pos]  = st_sync.paper_empty_flag;
    printer_status_lines[st_online_pos] = st_sync.printer_online_flag;
    printer_status_lines[st_error_pos]  = st_sync.error_n;
    printer_status_lines[2:0]           = st_low_ones;
  end

  assign ctrl_readback = {ct_high_ones, printer_control_lines};

  // Read data mux
  always_comb begin
    next_rdata = 8'h00;
    if (hit) begin
      unique case (reg_idx)
        off_data:   next_rdata = data_dir_in ? pd_sync : print_data_byte;
        off_status: next_rdata = printer_status_lines;
        off_ctrl:   next_rdata = ctrl_readback;
        default:    next_rdata = 8'h00;
      endcase
    end
  end

  // Registered read answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      io_rdata <= 8'h00;
      io_sel   <= 1'b0;
    end else begin
      io_sel <= (io_rd | io_wr) & hit;
      if (io_rd) begin
        io_rdata <= next_rdata;
      end
    end
  end

  // Data register write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      print_data_byte <= data_reset;
    end else if (io_wr && hit && reg_idx == off_data) begin
      print_data_byte <= io_wdata;
    end
  end

  // Control register write; top two bits are fixed ones
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      printer_control_lines <= ctrl_reset;
    end else if (io_wr && hit && reg_idx == off_ctrl) begin
      printer_control_lines <= io_wdata[5:0];
    end
  end

  // Data lines drive or release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pd_out <= data_reset;
      pd_oe  <= 8'hff;
    end else begin
      pd_out <= print_data_byte;
      pd_oe  <= {8{~data_dir_in}};
    end
  end

  // Control lines to the printer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_pins <= '{select: 1'b0, init_n: 1'b1, auto_feed: 1'b0, strobe: 1'b0};
    end else begin
      ctrl_pins.select    <= printer_control_lines[ct_select_pos];
      ctrl_pins.init_n    <= printer_control_lines[ct_init_pos];
      ctrl_pins.auto_feed <= printer_control_lines[ct_feed_pos];
      ctrl_pins.strobe    <= printer_control_lines[ct_strobe_pos];
    end
  end

  // Interrupt request level while ack is low and enabled
  assign irq_req = printer_control_lines[ct_irqen_pos] & ~st_sync.ack_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_line7 <= 1'b0;
      irq_line5 <= 1'b0;
    end else begin
      irq_line7 <= irq_req & irq_choice_jumper;
      irq_line5 <= irq_req & ~irq_choice_jumper;
    end
  end

  // Checks
  chk_irq_on_ack: assert property (@(posedge clk) disable iff (!nrst)
    (printer_control_lines[ct_irqen_pos] && !st_sync.ack_n && irq_choice_jumper) |=> irq_line7)
    else $error("irq7 not raised on low ack");
  chk_irq_off: assert property (@(posedge clk) disable iff (!nrst)
    !printer_control_lines[ct_irqen_pos] |=> !irq_line7 && !irq_line5)
    else $error("irq raised while disabled");
  chk_dir_ignored: assert property (@(posedge clk) disable iff (!nrst)
    !port_mode_jumper |=> pd_oe == 8'hff)
    else $error("data lines released outside bidir mode");
  chk_dir_release: assert property (@(posedge clk) disable iff (!nrst)
    (port_mode_jumper && printer_control_lines[ct_dir_pos]) |=> pd_oe == 8'h00)
    else $error("data lines not released");
  chk_data_drive: assert property (@(posedge clk) disable iff (!nrst)
    (io_wr && hit && reg_idx == off_data) ##1 !(io_wr && hit) |=> pd_out == $past(io_wdata, 2))
    else $error("data byte not driven");
  chk_status_ones: assert property (@(posedge clk) disable iff (!nrst)
    (io_rd && hit && reg_idx == off_status) |=> io_rdata[2:0] == 3'h7)
    else $error("status low bits not ones");
  chk_ctrl_readback: assert property (@(posedge clk) disable iff (!nrst)
    (io_wr && hit && reg_idx == off_ctrl) ##1 (io_rd && hit && reg_idx == off_ctrl && !io_wr)
      |=> io_rdata == {2'h3, $past(io_wdata[5:0], 2)})
    else $error("control readback mismatch");
  chk_decode_span: assert property (@(posedge clk) disable iff (!nrst)
    (io_rd && io_addr == base_addr + 10'h003) |=> !io_sel)
    else $error("fourth address decoded");
  chk_select_line: assert property (@(posedge clk) disable iff (!nrst)
    (io_wr && hit && reg_idx == off_ctrl && io_wdata[3]) |=> ##1 ctrl_pins.select)
    else $error("select not asserted");

  // Status read answers carry the synchronised printer lines
  chk_status_bits: assert property (@(posedge clk) disable iff (!nrst)
    (io_rd && hit && reg_idx == off_status) |=> io_rdata[7:3] == $past(st_sync))
    else $error("status bits differ from lines");

  chk_busy_bit: assert property (@(posedge clk) disable iff (!nrst)
    (io_rd && hit && reg_idx == off_status && !st_sync.busy) |=> !io_rdata[st_busy_pos])
    else $error("busy bit not low while blocked");

  chk_ack_bit: assert property (@(posedge clk) disable iff (!nrst)
    (io_rd && hit && reg_idx == off_status && !st_sync.ack_n) |=> !io_rdata[st_ack_pos])
    else $error("ack bit not low while ready");

  chk_status_write: assert property (@(posedge clk) disable iff (!nrst)
    (io_wr && hit && reg_idx == off_status) |=> $stable(print_data_byte) && $stable(printer_control_lines))
    else $error("status write changed a register");

  // Control and data read answers
  chk_ctrl_top_ones: assert property (@(posedge clk) disable iff (!nrst)
    (io_rd && hit && reg_idx == off_ctrl) |=> io_rdata[7:6] == 2'h3)
    else $error("control top bits not ones");

  chk_data_readback: assert property (@(posedge clk) disable iff (!nrst)
    (io_rd && hit && reg_idx == off_data && !data_dir_in) |=> io_rdata == $past(print_data_byte))
    else $error("data readback mismatch");

  chk_bidir_read: assert property (@(posedge clk) disable iff (!nrst)
    (io_rd && hit && reg_idx == off_data && data_dir_in) |=> io_rdata == $past(pd_sync))
    else $error("input data not read from lines");

  chk_rdata_hold: assert property (@(posedge clk) disable iff (!nrst)
    !io_rd |=> $stable(io_rdata))
    else $error("read data moved without a read");

  // Registers hold unless written
  chk_data_hold: assert property (@(posedge clk) disable iff (!nrst)
    !(io_wr && hit && reg_idx == off_data) |=> $stable(print_data_byte))
    else $error("data byte changed without write");

  chk_ctrl_hold: assert property (@(posedge clk) disable iff (!nrst)
    !(io_wr && hit && reg_idx == off_ctrl) |=> $stable(printer_control_lines))
    else $error("control changed without write");

  // Control lines follow a written control byte
  chk_ctrl_lines: assert property (@(posedge clk) disable iff (!nrst)
    (io_wr && hit && reg_idx == off_ctrl) ##1 !io_wr |=> ctrl_pins == $past(io_wdata[3:0], 2))
    else $error("control lines differ from write");

  chk_init_line: assert property (@(posedge clk) disable iff (!nrst)
    (io_wr && hit && reg_idx == off_ctrl && !io_wdata[2]) ##1 !io_wr |=> !ctrl_pins.init_n)
    else $error("init not asserted");

  // Data line direction
  chk_mode_drive: assert property (@(posedge clk) disable iff (!nrst)
    (port_mode_jumper && !printer_control_lines[ct_dir_pos]) |=> pd_oe == 8'hff)
    else $error("data lines released with direction out");

  chk_oe_levels: assert property (@(posedge clk) disable iff (!nrst)
    pd_oe == 8'hff || pd_oe == 8'h00)
    else $error("data line enables split");

  // Address window per slot
  chk_slot_first: assert property (@(posedge clk) disable iff (!nrst)
    (port_slot_jumper == slot_first && io_rd && io_addr == base_slot_first) |=> io_sel)
    else $error("first slot not decoded");

  chk_slot_third: assert property (@(posedge clk) disable iff (!nrst)
    (port_slot_jumper == slot_third && io_rd && io_addr == base_slot_third) |=> io_sel)
    else $error("third slot not decoded");

  chk_slot_delivery: assert property (@(posedge clk) disable iff (!nrst)
    (port_slot_jumper == slot_second && io_rd && io_addr == base_slot_second) |=> io_sel)
    else $error("delivery slot not decoded");

  chk_slot_spare: assert property (@(posedge clk) disable iff (!nrst)
    (port_slot_jumper == 2'b11 && io_rd && io_addr == base_slot_second) |=> io_sel)
    else $error("spare code not on delivery slot");

  chk_below_base: assert property (@(posedge clk) disable iff (!nrst)
    ((io_rd || io_wr) && io_addr == base_addr - 10'h001) |=> !io_sel)
    else $error("address below base decoded");

  // Interrupt lines
  chk_irq5_on_ack: assert property (@(posedge clk) disable iff (!nrst)
    (printer_control_lines[ct_irqen_pos] && !st_sync.ack_n && !irq_choice_jumper) |=> irq_line5)
    else $error("irq5 not raised on low ack");

  chk_irq_quiet: assert property (@(posedge clk) disable iff (!nrst)
    st_sync.ack_n |=> !irq_line7 && !irq_line5)
    else $error("irq raised while ack high");

  chk_irq7_unused: assert property (@(posedge clk) disable iff (!nrst)
    !irq_choice_jumper |=> !irq_line7)
    else $error("irq7 raised while not chosen");

  chk_irq5_unused: assert property (@(posedge clk) disable iff (!nrst)
    irq_choice_jumper |=> !irq_line5)
    else $error("irq5 raised while not chosen");

  cov_irq7: cover property (@(posedge clk) disable iff (!nrst) $rose(irq_line7));
  cov_bidir_read: cover property (@(posedge clk) disable iff (!nrst)
    io_rd && hit && reg_idx == off_data && data_dir_in);
  cov_strobe: cover property (@(posedge clk) disable iff (!nrst) $rose(ctrl_pins.strobe));
  cov_third_slot: cover property (@(posedge clk) disable iff (!nrst)
    port_slot_jumper == slot_third && io_sel);

endmodule : isa_printer_port

/* sim/printer_model.sv */
`timescale 1ns/1ns
module printer_model (
  input  wire logic                         clk,
  input  wire lpt_port_pkg::ctrl_lines_type ctrl_pins,
  input  wire logic [7:0]                   pd_out,
  input  wire logic [7:0]                   pd_oe,
  input  wire logic                         drv,
  input  wire logic [7:0]                   byte_in,
  input  wire logic [3:0]                   ack_delay,
  output logic                              busy,
  output logic                              ack_n,
  output logic [7:0]                        pd_line,
  output logic [7:0]                        seen_byte
);
  import lpt_port_pkg::*;
  logic       strobe_q;
  logic [7:0] last;
  int         cnt;
  // Wire level: port wins, then printer, else a pattern that keeps changing
  assign pd_line = (pd_oe & pd_out) | (~pd_oe & (drv ? byte_in : ~last));
  // Idle printer can take data
  initial begin
    busy = 1'b1;
    ack_n = 1'b1;
    cnt = 0;
    strobe_q = 1'b0;
    last = 8'h00;
    seen_byte = 8'h00;
  end
  // Latch on strobe rise, stay blocked, pulse acknowledge low, then free
  always @(posedge clk) begin
    strobe_q <= ctrl_pins.strobe;
    last <= pd_line;
    if (ctrl_pins.strobe && !strobe_q) begin
      seen_byte <= pd_line;
      busy <= 1'b0;
      cnt <= ack_delay + 7;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      ack_n <= !(cnt <= 7 && cnt >= 2);
      busy <= (cnt == 1);
    end
  end
endmodule : printer_model

/* sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import lpt_port_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, io_rd = 1'b0, io_wr = 1'b0, io_sel;
  logic [9:0] io_addr = 10'h000, base;
  logic [7:0] io_wdata = 8'h00, io_rdata, pd_out, pd_oe, pd_line, seen_byte, d, mdl_data, mdl_ctrl;
  logic [7:0] byte_in = 8'h00;
  logic [3:0] ack_delay = 4'h0;
  slot_type port_slot_jumper = slot_second;
  logic port_mode_jumper = 1'b0, irq_choice_jumper = 1'b0, drv = 1'b0;
  logic pe = 1'b0, online = 1'b1, err_n = 1'b1, busy, ack_n, irq_line7, irq_line5;
  ctrl_lines_type ctrl_pins;
  int err_count = 0, samples_checked = 0, seed, i;
  always #20 clk = ~clk;
  isa_printer_port isa_printer_port_inst (.clk(clk), .nrst(nrst), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_sel(io_sel),
    .port_slot_jumper(port_slot_jumper), .port_mode_jumper(port_mode_jumper),
    .irq_choice_jumper(irq_choice_jumper), .pd_in(pd_line), .pd_out(pd_out), .pd_oe(pd_oe),
    .status_pins({busy, ack_n, pe, online, err_n}), .ctrl_pins(ctrl_pins),
    .irq_line7(irq_line7), .irq_line5(irq_line5));
  printer_model printer_model_inst (.clk(clk), .ctrl_pins(ctrl_pins), .pd_out(pd_out), .pd_oe(pd_oe),
    .drv(drv), .byte_in(byte_in), .ack_delay(ack_delay), .busy(busy), .ack_n(ack_n),
    .pd_line(pd_line), .seen_byte(seen_byte));
  task automatic summarize;
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  function automatic logic hit(input logic [9:0] a);
    return a >= base && a <= base + 10'd2;
  endfunction : hit
  // Expected read value from the bench model of the registers
  function automatic logic [7:0] exp_at(input logic [9:0] a);
    if (!hit(a)) return 8'h00;
    if (a == base) return (port_mode_jumper && mdl_ctrl[ct_dir_pos]) ? byte_in : mdl_data;
    if (a == base + 10'd1) return {busy, ack_n, pe, online, err_n, st_low_ones};
    return mdl_ctrl;
  endfunction : exp_at
  task automatic rst(input slot_type s, input logic m, input logic q, input int n);
    nrst = 1'b0;
    port_slot_jumper = s;
    port_mode_jumper = m;
    irq_choice_jumper = q;
    repeat (n) @(posedge clk);
    #1 nrst = 1'b1;
    base = (s == slot_first) ? base_slot_first : (s == slot_third) ? base_slot_third : base_slot_second;
    mdl_data = data_reset;
    mdl_ctrl = {ct_high_ones, ctrl_reset};
  endtask : rst
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 io_wr = 1'b1;
    io_addr = a;
    io_wdata = v;
    @(posedge clk);
    #1 io_wr = 1'b0;
    chk8({7'h0, io_sel}, {7'h0, hit(a)});
    if (hit(a) && a == base) mdl_data = v;
    if (hit(a) && a == base + 10'd2) mdl_ctrl = {ct_high_ones, v[5:0]};
  endtask : wr
  task automatic rd(input logic [9:0] a);
    logic [7:0] e;
    @(posedge clk);
    #1 io_rd = 1'b1;
    io_addr = a;
    e = exp_at(a);
    @(posedge clk);
    #1 io_rd = 1'b0;
    chk8({7'h0, io_sel}, {7'h0, hit(a)});
    chk8(io_rdata, e);
  endtask : rd
  // Bounded wait: 0 ack low, 1 line 7, 2 line 5, 3 printer idle
  task automatic wait_ev(input int w, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      #1;
      if (w == 0 ? !ack_n : w == 1 ? irq_line7 : w == 2 ? irq_line5 : busy && ack_n) return;
    end
    err_count++;
    summarize();
  endtask : wait_ev
  // Main sequence
  initial begin
    seed = 69233;
    rst(slot_second, 1'b0, 1'b0, 16);
    rd(base);
    rd(base + 10'd1);
    rd(base + 10'd2);
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      wr(base, d);
      rd(base);
      chk8(pd_out, d);
      chk8(pd_oe, 8'hff);
    end
    for (i = 0; i < 64; i++) begin
      d = 8'($random(seed));
      wr(base + 10'd2, {d[7:6], i[5:0]});
      rd(base + 10'd2);
      chk8({4'h0, ctrl_pins}, {4'h0, i[3:0]});
      chk8(pd_oe, 8'hff);
    end
    wr(base + 10'd2, 8'h04);
    wait_ev(3, 40);
    for (i = 0; i < 8; i++) begin
      {pe, online, err_n} = 3'($random(seed));
      repeat (3) @(posedge clk);
      rd(base + 10'd1);
    end
    // Print handshake, with and without the acknowledge interrupt
    for (i = 0; i < 2; i++) begin
      rst(slot_first, 1'b0, i[0], 2);
      ack_delay = 4'($random(seed));
      d = 8'($random(seed));
      wr(base, d);
      wr(base + 10'd2, 8'h15);
      wr(base + 10'd2, 8'h14);
      wait_ev(0, 40);
      repeat (2) @(posedge clk);
      rd(base + 10'd1);
      wait_ev(2 - i, 8);
      chk8({7'h0, i[0] ? irq_line5 : irq_line7}, 8'h00);
      chk8(seen_byte, d);
      wait_ev(3, 40);
      wr(base + 10'd2, 8'h05);
      wr(base + 10'd2, 8'h04);
      wait_ev(0, 40);
      repeat (4) @(posedge clk);
      chk8({6'h0, irq_line7, irq_line5}, 8'h00);
    end
    // Bidirectional mode, lines turned round and back
    rst(slot_third, 1'b1, 1'b0, 2);
    byte_in = 8'($random(seed));
    drv = 1'b1;
    wr(base + 10'd2, 8'h24);
    repeat (3) @(posedge clk);
    rd(base);
    chk8(pd_oe, 8'h00);
    drv = 1'b0;
    wr(base + 10'd2, 8'h04);
    rd(base);
    chk8(pd_oe, 8'hff);
    // Window edges of every slot
    for (i = 0; i < 3; i++) begin
      rst(slot_type'(i[1:0]), 1'b0, 1'b0, 2);
      d = 8'($random(seed));
      wr(base, d);
      wr(base - 10'd1, ~d);
      wr(base + 10'd3, ~d);
      wr(base + 10'd1, ~d);
      rd(base - 10'd1);
      rd(base + 10'd3);
      rd(base);
    end
    summarize();
  end
endmodule : tb_top
